// [pwmg_top.sv]
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pwmg_cfg.svh"

module pwmg_top (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic ext_sync_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [3:0] output_a_o,
    output logic [3:0] output_b_o
);
    localparam int NSM = 4;

    // signed greater-or-equal compare, used by every edge comparator
    function automatic logic ge_cmp(input logic [15:0] cnt, input logic [15:0] val);
        ge_cmp = ($signed(cnt) >= $signed(val));
    endfunction : ge_cmp

    pwmg_pkg::pwmg_sm_cfg_t cfg [NSM];
    logic [3:0] pair_signal_swap;
    logic [15:0] count [NSM];
    logic [NSM-1:0] first_edge_pair_signal;
    logic [NSM-1:0] second_edge_pair_signal;
    logic [NSM-1:0] local_sync;

    // bus decode
    wire logic setup_w = psel_i && !penable_i;
    wire logic wr_w = psel_i && penable_i && pwrite_i;
    wire logic [1:0] sm_idx_w = paddr_i[7:6];
    wire logic [7:0] sm_off_w = {2'h0, paddr_i[5:0]};
    wire logic in_sm_w = (paddr_i[11:8] == 4'h0) && (paddr_i[1:0] == 2'h0) && (paddr_i[5:0] <= 6'h1C);
    wire logic is_module_master_control_w = (paddr_i == `PWMG_OFF_MODULE_MASTER_CONTROL);
    wire logic mapped_w = in_sm_w || is_module_master_control_w;

    // master reload and sync both come from submodule 0's period end
    wire logic master_pulse_w = local_sync[0];

    // per-submodule time base and compare logic
    genvar g;
    generate
        for (g = 0; g < NSM; g++) begin : g_sm
            logic init_evt;
            logic set_a;
            logic clr_a;
            logic set_b;
            logic clr_b;
            // local sync ends a period when the counter meets the modulus
            assign local_sync[g] = cfg[g].run && ge_cmp(count[g], cfg[g].counter_modulus);
            // init source selected per submodule; master reload or sync locks its phase to submodule 0
            always_comb begin
                unique case (cfg[g].init_sel)
                    pwmg_pkg::PWMG_INIT_LOCAL: init_evt = local_sync[g];
                    pwmg_pkg::PWMG_INIT_MASTER_RELOAD: init_evt = master_pulse_w;
                    pwmg_pkg::PWMG_INIT_MASTER_SYNC: init_evt = master_pulse_w;
                    pwmg_pkg::PWMG_INIT_EXT_SYNC: init_evt = ext_sync_i;
                endcase
            end
            // set at turn-on, clear at turn-off; turn-on at init gives edge alignment
            assign set_a = ge_cmp(count[g], cfg[g].a_turn_on_value);
            assign clr_a = ge_cmp(count[g], cfg[g].a_turn_off_value);
            assign set_b = ge_cmp(count[g], cfg[g].b_turn_on_value);
            assign clr_b = ge_cmp(count[g], cfg[g].b_turn_off_value);

            // counter: reload initial value the clock after the period end
            always_ff @(posedge mclk_i) begin
                if (!reset_n_i) begin
                    count[g] <= `PWMG_RST_INIT; // constant, since the init register resets in this same edge
                end else if (!cfg[g].run) begin
                    count[g] <= cfg[g].init_value;
                end else if (init_evt) begin
                    count[g] <= cfg[g].init_value;
                end else begin
                    count[g] <= count[g] + 16'h0001;
                end
            end

            // set/reset flops; reset dominates when both compares fire
            always_ff @(posedge mclk_i) begin
                if (!reset_n_i || !cfg[g].run) begin
                    first_edge_pair_signal[g] <= 1'b0;
                    second_edge_pair_signal[g] <= 1'b0;
                end else begin
                    first_edge_pair_signal[g] <= !clr_a && (set_a || first_edge_pair_signal[g]);
                    second_edge_pair_signal[g] <= !clr_b && (set_b || second_edge_pair_signal[g]);
                end
            end

            // output select: complementary pair or independent channels
            wire logic comp_src = pair_signal_swap[g] ? second_edge_pair_signal[g] : first_edge_pair_signal[g];
            wire logic next_a = cfg[g].independent_pair_select ? first_edge_pair_signal[g] : comp_src;
            wire logic next_b = cfg[g].independent_pair_select ? second_edge_pair_signal[g] : !comp_src;
            // registered pins; no deadtime here, power stage sees one extra clock of latency
            always_ff @(posedge mclk_i) begin
                if (!reset_n_i) begin
                    output_a_o[g] <= 1'b0;
                    output_b_o[g] <= 1'b0;
                end else begin
                    output_a_o[g] <= next_a && cfg[g].run;
                    output_b_o[g] <= next_b && cfg[g].run;
                end
            end

            // register writes for this submodule
            always_ff @(posedge mclk_i) begin
                if (!reset_n_i) begin
                    cfg[g].init_value <= `PWMG_RST_INIT;
                    cfg[g].counter_modulus <= `PWMG_RST_MOD;
                    cfg[g].a_turn_on_value <= `PWMG_RST_VAL;
                    cfg[g].a_turn_off_value <= `PWMG_RST_VAL;
                    cfg[g].b_turn_on_value <= `PWMG_RST_VAL;
                    cfg[g].b_turn_off_value <= `PWMG_RST_VAL;
                    cfg[g].run <= 1'b0;
                    cfg[g].init_sel <= pwmg_pkg::PWMG_INIT_LOCAL;
                    cfg[g].independent_pair_select <= 1'b0;
                end else if (wr_w && in_sm_w && sm_idx_w == 2'(g)) begin
                    unique case (sm_off_w)
                        8'(`PWMG_OFF_INIT): cfg[g].init_value <= pwdata_i[15:0];
                        8'(`PWMG_OFF_MOD): cfg[g].counter_modulus <= pwdata_i[15:0];
                        8'(`PWMG_OFF_A_ON): cfg[g].a_turn_on_value <= pwdata_i[15:0];
                        8'(`PWMG_OFF_A_OFF): cfg[g].a_turn_off_value <= pwdata_i[15:0];
                        8'(`PWMG_OFF_B_ON): cfg[g].b_turn_on_value <= pwdata_i[15:0];
                        8'(`PWMG_OFF_B_OFF): cfg[g].b_turn_off_value <= pwdata_i[15:0];
                        8'(`PWMG_OFF_SUBMODULE_CONTROL_TWO): begin
                            cfg[g].independent_pair_select <= pwdata_i[`PWMG_SUBMODULE_CONTROL_TWO_INDEPENDENT_PAIR_SELECT_BIT];
                            cfg[g].init_sel <= pwmg_pkg::pwmg_init_src_t'(pwdata_i[`PWMG_SUBMODULE_CONTROL_TWO_INIT_SEL_LSB +: 2]);
                            cfg[g].run <= pwdata_i[`PWMG_SUBMODULE_CONTROL_TWO_RUN_BIT];
                        end
                        default: ; // counter is read only
                    endcase
                end
            end
        end
    endgenerate

    // module master control write
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pair_signal_swap <= 4'h0;
        end else if (wr_w && is_module_master_control_w) begin
            pair_signal_swap <= pwdata_i[`PWMG_MODULE_MASTER_CONTROL_SWAP_LSB +: 4];
        end
    end

    // read mux, computed in the setup cycle
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (is_module_master_control_w) begin
            rd_mux = {28'h000_0000, pair_signal_swap};
        end else if (in_sm_w) begin
            unique case (sm_off_w)
                8'(`PWMG_OFF_INIT): rd_mux = {16'h0000, cfg[sm_idx_w].init_value};
                8'(`PWMG_OFF_MOD): rd_mux = {16'h0000, cfg[sm_idx_w].counter_modulus};
                8'(`PWMG_OFF_A_ON): rd_mux = {16'h0000, cfg[sm_idx_w].a_turn_on_value};
                8'(`PWMG_OFF_A_OFF): rd_mux = {16'h0000, cfg[sm_idx_w].a_turn_off_value};
                8'(`PWMG_OFF_B_ON): rd_mux = {16'h0000, cfg[sm_idx_w].b_turn_on_value};
                8'(`PWMG_OFF_B_OFF): rd_mux = {16'h0000, cfg[sm_idx_w].b_turn_off_value};
                8'(`PWMG_OFF_SUBMODULE_CONTROL_TWO): rd_mux = {28'h000_0000, cfg[sm_idx_w].run, cfg[sm_idx_w].init_sel,
                    cfg[sm_idx_w].independent_pair_select};
                8'(`PWMG_OFF_COUNT): rd_mux = {16'h0000, count[sm_idx_w]};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // apb answer: ready one cycle after setup, so every access has one wait-free access phase
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= setup_w;
            pslverr_o <= setup_w && !mapped_w;
            prdata_o <= (setup_w && !pwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end
endmodule : pwmg_top

`default_nettype wire

// [pwmg_cfg.svh]
`ifndef PWMG_CFG_SVH
`define PWMG_CFG_SVH
// byte addresses; submodule n block at n * PWMG_SM_STRIDE
`define PWMG_SM_STRIDE 12'h040
`define PWMG_OFF_INIT 12'h000
`define PWMG_OFF_MOD 12'h004
`define PWMG_OFF_A_ON 12'h008
`define PWMG_OFF_A_OFF 12'h00C
`define PWMG_OFF_B_ON 12'h010
`define PWMG_OFF_B_OFF 12'h014
`define PWMG_OFF_SUBMODULE_CONTROL_TWO 12'h018
`define PWMG_OFF_COUNT 12'h01C
`define PWMG_OFF_MODULE_MASTER_CONTROL 12'h100
// submodule control two fields
`define PWMG_SUBMODULE_CONTROL_TWO_INDEPENDENT_PAIR_SELECT_BIT 0
`define PWMG_SUBMODULE_CONTROL_TWO_INIT_SEL_LSB 1
`define PWMG_SUBMODULE_CONTROL_TWO_RUN_BIT 3
// module master control fields: swap bits 3:0, one per submodule
`define PWMG_MODULE_MASTER_CONTROL_SWAP_LSB 0
// reset values
`define PWMG_RST_INIT 16'h0000
`define PWMG_RST_MOD 16'hFFFF
`define PWMG_RST_VAL 16'h0000
`define PWMG_RST_SUBMODULE_CONTROL_TWO 4'h0
`endif

// [pwmg_pkg.sv]
package pwmg_pkg;
    typedef enum logic [1:0] {
        PWMG_INIT_LOCAL,
        PWMG_INIT_MASTER_RELOAD,
        PWMG_INIT_MASTER_SYNC,
        PWMG_INIT_EXT_SYNC
    } pwmg_init_src_t;

    typedef struct packed {
        logic [15:0] init_value;
        logic [15:0] counter_modulus;
        logic [15:0] a_turn_on_value;
        logic [15:0] a_turn_off_value;
        logic [15:0] b_turn_on_value;
        logic [15:0] b_turn_off_value;
        logic run;
        pwmg_init_src_t init_sel;
        logic independent_pair_select;
    } pwmg_sm_cfg_t;

    typedef struct packed {
        logic output_a;
        logic output_b;
    } pwmg_pair_t;
endpackage : pwmg_pkg

// [pwmg_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module pwmg_chk (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic ext_sync_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [3:0] output_a_o,
    input wire logic [3:0] output_b_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    logic indep0, run0;
    logic [2:0] quiet;
    wire wr = psel_i && penable_i && pwrite_i && pready_o;
    // shadow of submodule 0 mode; quiet lets pins settle after any write
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            indep0 <= 1'b0;
            run0 <= 1'b0;
            quiet <= 3'h0;
        end else begin
            if (wr && paddr_i == 12'h018) begin
                indep0 <= pwdata_i[0];
                run0 <= pwdata_i[3];
            end
            quiet <= wr ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
        end
    end
    ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
    ready_one_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
    ready_has_cause_a: assert property (pready_o |-> $past(psel_i && !penable_i)) else $error("ready uncaused");
    err_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h00000000) else $error("read data not idle");
    reset_quiet_a: assert property ($rose(reset_n_i) |-> output_a_o == 4'h0 && output_b_o == 4'h0) else $error("pins after reset");
    comp_pair_a: assert property (run0 && !indep0 && quiet == 3'h7 |-> output_b_o[0] != output_a_o[0])
        else $error("pair not complementary");
    stop_quiet_a: assert property (!run0 && quiet == 3'h7 |-> !output_a_o[0] && !output_b_o[0])
        else $error("stopped pins active");
    cover property (wr && paddr_i == 12'h018);
    cover property (pslverr_o);
    cover property ($rose(output_a_o[0]));
endmodule : pwmg_chk
`default_nettype wire

// [pwmg_bridge.sv]
`timescale 1ns/100ps
`default_nettype none
module pwmg_bridge (
    input wire logic mclk_i,
    input wire logic [3:0] high_i,
    input wire logic [3:0] low_i,
    output logic [3:0] shoot_o
);
    // both switches of a leg on at once shorts the supply
    always_ff @(posedge mclk_i) begin
        shoot_o <= high_i & low_i;
    end
endmodule : pwmg_bridge
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic mclk_i, reset_n_i, psel_i, penable_i, pwrite_i, ext_sync_i, pready_o, pslverr_o, err;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0] output_a_o, output_b_o, shoot, pa, pb, fa, fb, m_swap;
    logic [15:0] m_init[4], m_mod[4], m_aon[4], m_aoff[4], m_bon[4], m_boff[4], m_cnt[4];
    logic [3:0] m_ctrl[4];
    int errors = 0, tests_run = 0, quiet = 0;
    function automatic logic ge(input logic [15:0] a, input logic [15:0] b);
        return $signed(a) >= $signed(b);
    endfunction : ge
    wire mw = psel_i && penable_i && pwrite_i && pready_o;
    wire p0end = m_ctrl[0][3] && ge(m_cnt[0], m_mod[0]);
    pwmg_top uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .ext_sync_i(ext_sync_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .output_a_o(output_a_o), .output_b_o(output_b_o));
    pwmg_bridge u_bridge (.mclk_i(mclk_i), .high_i(output_a_o), .low_i(output_b_o), .shoot_o(shoot));
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) ext_sync_i <= ($urandom % 16) == 0;
    // reference: registers snooped off the bus, counter and set/reset flops per submodule
    always @(posedge mclk_i) begin
        quiet <= (!reset_n_i || mw) ? 0 : quiet + 1;
        if (mw && paddr_i == 12'h100) m_swap <= pwdata_i[3:0];
        for (int n = 0; n < 4; n++) begin
            if (mw && paddr_i[11:6] == 6'(n)) begin
                case (paddr_i[5:0])
                    6'h00: m_init[n] <= pwdata_i[15:0];
                    6'h04: m_mod[n] <= pwdata_i[15:0];
                    6'h08: m_aon[n] <= pwdata_i[15:0];
                    6'h0C: m_aoff[n] <= pwdata_i[15:0];
                    6'h10: m_bon[n] <= pwdata_i[15:0];
                    6'h14: m_boff[n] <= pwdata_i[15:0];
                    6'h18: m_ctrl[n] <= pwdata_i[3:0];
                    default: ;
                endcase
            end
            if (!m_ctrl[n][3] || (m_ctrl[n][2:1] == 2'h0 ? ge(m_cnt[n], m_mod[n]) :
                m_ctrl[n][2:1] == 2'h3 ? ext_sync_i : p0end)) m_cnt[n] <= m_init[n];
            else m_cnt[n] <= m_cnt[n] + 16'h0001;
            fa[n] <= ge(m_cnt[n], m_aoff[n]) ? 1'b0 : (ge(m_cnt[n], m_aon[n]) ? 1'b1 : fa[n]);
            fb[n] <= ge(m_cnt[n], m_boff[n]) ? 1'b0 : (ge(m_cnt[n], m_bon[n]) ? 1'b1 : fb[n]);
            pa[n] <= m_ctrl[n][3] && (m_ctrl[n][0] ? fa[n] : (m_swap[n] ? fb[n] : fa[n]));
            pb[n] <= m_ctrl[n][3] && (m_ctrl[n][0] ? fb[n] : !(m_swap[n] ? fb[n] : fa[n]));
            if (!reset_n_i) begin
                {m_init[n], m_aon[n], m_aoff[n], m_bon[n], m_boff[n], m_cnt[n]} <= '0;
                {m_mod[n], m_ctrl[n], fa[n], fb[n], pa[n], pb[n], m_swap[n]} <= {16'hFFFF, 9'h000};
            end
        end
    end
    // pins checked every settled cycle, clear of the launch edge
    always @(negedge mclk_i) begin
        if (reset_n_i && quiet >= 5) begin
            `CHK(output_a_o, pa)
            `CHK(output_b_o, pb)
            `CHK(shoot[1], 1'b0)
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge mclk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin @(posedge mclk_i); k++; end while (pready_o !== 1'b1 && k < 20);
        rd = prdata_o;
        err = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd, e)
        `CHK(err, ee)
    endtask : rdchk
    task automatic cfg(input int n, input logic [15:0] i, m, ao, af, bo, bf, input logic [3:0] c);
        logic [15:0] v[6] = '{i, m, ao, af, bo, bf};
        for (int r = 0; r < 6; r++) apb(1'b1, 12'(n * 64 + r * 4), {16'h0000, v[r]});
        apb(1'b1, 12'(n * 64 + 24), {28'h0000000, c});
    endtask : cfg
    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #(20 * 6000);
        errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(47040));
        {reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        repeat (4) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        for (int n = 0; n < 4; n++) rdchk(12'(n * 64 + 4), 32'h0000FFFF, 1'b0);
        rdchk(12'h020, 32'h00000000, 1'b1);
        apb(1'b1, 12'h0C0, 32'hABCD1234);
        rdchk(12'h0C0, 32'h00001234, 1'b0);
        apb(1'b1, 12'h0DC, 32'h00000055);
        rdchk(12'h0DC, 32'h00001234, 1'b0);
        cfg(0, 16'h0000, 16'h000B, 16'h0000, 16'(1 + $urandom % 11), 16'h0000, 16'(1 + $urandom % 11), 4'h9);
        cfg(1, 16'hFFF8, 16'h0007, 16'hFFFE, 16'h0002, 16'h0000, 16'h0000, 4'h8);
        cfg(2, 16'h0000, 16'h000B, 16'h0001, 16'h0004, 16'h0007, 16'h000A, 4'h9);
        cfg(3, 16'h0000, 16'h0005, 16'h0003, 16'h0003, 16'h0002, 16'h0005, 4'h9);
        repeat (80) @(posedge mclk_i);
        apb(1'b1, 12'h100, 32'h0000000F);
        cfg(1, 16'hFFF8, 16'h7FFF, 16'hFFFE, 16'h0002, 16'hFFFD, 16'h0003, 4'hA);
        cfg(2, 16'h0000, 16'h7FFF, 16'h0003, 16'h0008, 16'h0003, 16'h0008, 4'hD);
        cfg(3, 16'h0000, 16'h7FFF, 16'h0001, 16'h0006, 16'h0002, 16'h0004, 4'hF);
        apb(1'b1, 12'h018, 32'h00000008);
        repeat (100) @(posedge mclk_i);
        report_and_stop();
    end
endmodule : tb_top
bind pwmg_top pwmg_chk u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .ext_sync_i(ext_sync_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .output_a_o(output_a_o), .output_b_o(output_b_o));
`default_nettype wire
